// [logic/caf_acceptance_filter_control.sv]
// Acceptance filter control word for four receive filters
//
// What this block does
// R1: Bit 31 enables filter fifteen when set, disables when cleared.
// R2: Bits 30-29 pick acceptance mask zero to three for filter fifteen.
// R3: Bits 28-24 name receive buffer 0 to 31 for filter fifteen.
// R4: Bit 23 enables filter fourteen when set, disables when cleared.
// R5: Bits 22-21 pick acceptance mask zero to three for filter fourteen.
// R6: Bits 20-16 name receive buffer 0 to 31 for filter fourteen.
// R7: Mask and buffer picks change only while that filter is disabled.
// R8: Filters thirteen and twelve use bytes one and zero; all fields reset zero.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module caf_acceptance_filter_control
   import caf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [CAF_ADDR_W-1:0] regAddr,
   input wire logic [CAF_DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [CAF_DATA_W-1:0] regRdData,
   output logic [CAF_NUM_FILT-1:0] filterOn,
   output logic [CAF_NUM_FILT*CAF_MASK_W-1:0] filterMaskPick,
   output logic [CAF_NUM_FILT*CAF_BUF_W-1:0] filterBufferPick
);
   logic [CAF_DATA_W-1:0] ctrlWord;
   logic [CAF_NUM_FILT-1:0] slotRefused;
   logic ctrlHit;
   logic [CAF_DATA_W-1:0] rdData_reg;
   logic [CAF_DATA_W-1:0] rdData_next;
   logic [CAF_NUM_FILT-1:0] refused_reg;
   logic [CAF_NUM_FILT-1:0] refused_next;
   logic [CAF_NUM_FILT-1:0] on_reg;
   logic [CAF_NUM_FILT*CAF_MASK_W-1:0] mask_reg;
   logic [CAF_NUM_FILT*CAF_BUF_W-1:0] buf_reg;
   logic [CAF_NUM_FILT-1:0] on_next;
   logic [CAF_NUM_FILT*CAF_MASK_W-1:0] mask_next;
   logic [CAF_NUM_FILT*CAF_BUF_W-1:0] buf_next;

   assign ctrlHit = regWrite && (regAddr == CAF_CTRL3_ADDR);

   // Slot 3 is filter fifteen, slot 2 fourteen, slot 1 thirteen, slot 0 twelve
   for (genvar g = 0; g < CAF_NUM_FILT; g++) begin : g_slot
      caf_slot_if slotBus ();
      assign slotBus.wrEn = ctrlHit;
      assign slotBus.wrData = regWrData[g*CAF_SLOT_W +: CAF_SLOT_W]; // R8
      assign ctrlWord[g*CAF_SLOT_W +: CAF_SLOT_W] = slotBus.slotVal;
      assign slotRefused[g] = slotBus.refused;
      caf_filter_slot u_slot (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .bus(slotBus.slot)
      );
      always_comb begin
         on_next[g] = ctrlWord[g*CAF_SLOT_W + CAF_ON_POS]; // R1 R4
         mask_next[g*CAF_MASK_W +: CAF_MASK_W] =
            ctrlWord[g*CAF_SLOT_W + CAF_MASK_LO +: CAF_MASK_W]; // R2 R5
         buf_next[g*CAF_BUF_W +: CAF_BUF_W] =
            ctrlWord[g*CAF_SLOT_W + CAF_BUF_LO +: CAF_BUF_W]; // R3 R6
      end
   end

   // Sticky record of refused setting writes, cleared by writing ones
   always_comb begin
      refused_next = refused_reg;
      if (regWrite && (regAddr == CAF_WRITE_REFUSED_ADDR)) begin
         refused_next = refused_reg & ~regWrData[CAF_NUM_FILT-1:0];
      end
      refused_next = refused_next | slotRefused; // R7
   end

   always_comb begin
      rdData_next = CAF_ZERO_WORD;
      if (regRead && (regAddr == CAF_CTRL3_ADDR)) begin
         rdData_next = ctrlWord;
      end else if (regRead && (regAddr == CAF_WRITE_REFUSED_ADDR)) begin
         rdData_next[CAF_NUM_FILT-1:0] = refused_reg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdData_reg <= CAF_ZERO_WORD;
         refused_reg <= '0;
         on_reg <= '0; // R8
         mask_reg <= '0;
         buf_reg <= '0;
      end else begin
         rdData_reg <= rdData_next;
         refused_reg <= refused_next;
         on_reg <= on_next;
         mask_reg <= mask_next;
         buf_reg <= buf_next;
      end
   end

   assign regRdData = rdData_reg;
   assign filterOn = on_reg;
   assign filterMaskPick = mask_reg;
   assign filterBufferPick = buf_reg;

   a_readback_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      regRead && regAddr == CAF_CTRL3_ADDR |=> regRdData == $past(ctrlWord))
      else $error("Read data not the control word");
   a_mask_fifteen_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
      filterMaskPick[3*CAF_MASK_W +: CAF_MASK_W] == $past(ctrlWord[30:29]))
      else $error("Filter fifteen mask output wrong");
   a_buf_fourteen_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
      filterBufferPick[2*CAF_BUF_W +: CAF_BUF_W] == $past(ctrlWord[20:16]))
      else $error("Filter fourteen buffer output wrong");
   a_on_fourteen_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
      ctrlHit ##1 1'b1 |=> filterOn[2] == $past(regWrData[23], 2))
      else $error("Filter fourteen enable output wrong");
   a_mask_fourteen_lock: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
      ctrlWord[23] && !ctrlHit |=> $stable(ctrlWord[22:21]))
      else $error("Filter fourteen mask moved while enabled");

   // Enable outputs follow the stored enable bits one cycle later
   a_on_fifteen_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
      ctrlHit ##1 1'b1 |=> filterOn[3] == $past(regWrData[31], 2))
      else $error("Filter fifteen enable output wrong");

   a_on_fifteen_level: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
      filterOn[3] == $past(ctrlWord[31]))
      else $error("Filter fifteen enable level wrong");

   a_on_fourteen_level: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
      filterOn[2] == $past(ctrlWord[23]))
      else $error("Filter fourteen enable level wrong");

   a_on_thirteen_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      filterOn[1] == $past(ctrlWord[15]))
      else $error("Filter thirteen enable output wrong");

   a_on_twelve_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      filterOn[0] == $past(ctrlWord[7]))
      else $error("Filter twelve enable output wrong");

   // Mask and buffer outputs follow the stored fields one cycle later
   a_buf_fifteen_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
      filterBufferPick[19:15] == $past(ctrlWord[28:24]))
      else $error("Filter fifteen buffer output wrong");

   a_mask_fourteen_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
      filterMaskPick[5:4] == $past(ctrlWord[22:21]))
      else $error("Filter fourteen mask output wrong");

   a_mask_thirteen_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      filterMaskPick[3:2] == $past(ctrlWord[14:13]))
      else $error("Filter thirteen mask output wrong");

   a_mask_twelve_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      filterMaskPick[1:0] == $past(ctrlWord[6:5]))
      else $error("Filter twelve mask output wrong");

   a_buf_thirteen_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      filterBufferPick[9:5] == $past(ctrlWord[12:8]))
      else $error("Filter thirteen buffer output wrong");

   a_buf_twelve_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      filterBufferPick[4:0] == $past(ctrlWord[4:0]))
      else $error("Filter twelve buffer output wrong");

   // Settings of an enabled filter never move, written or not
   a_mask_fifteen_lock: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
      ctrlWord[31] |=> $stable(ctrlWord[30:29]))
      else $error("Filter fifteen mask moved while enabled");

   a_buf_fifteen_lock: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
      ctrlWord[31] |=> $stable(ctrlWord[28:24]))
      else $error("Filter fifteen buffer moved while enabled");

   a_buf_fourteen_lock: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
      ctrlWord[23] |=> $stable(ctrlWord[20:16]))
      else $error("Filter fourteen buffer moved while enabled");

   a_thirteen_lock: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      ctrlWord[15] |=> $stable(ctrlWord[14:8]))
      else $error("Filter thirteen settings moved while enabled");

   a_twelve_lock: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      ctrlWord[7] |=> $stable(ctrlWord[6:0]))
      else $error("Filter twelve settings moved while enabled");

   // Writes to a disabled filter take the whole byte
   a_fifteen_open_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
      ctrlHit && !ctrlWord[31] |=> ctrlWord[31:24] == $past(regWrData[31:24]))
      else $error("Filter fifteen write not stored");

   a_fourteen_open_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
      ctrlHit && !ctrlWord[23] |=> ctrlWord[23:16] == $past(regWrData[23:16]))
      else $error("Filter fourteen write not stored");

   a_on_fifteen_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
      ctrlHit |=> ctrlWord[31] == $past(regWrData[31]))
      else $error("Filter fifteen enable not written");

   a_on_fourteen_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
      ctrlHit |=> ctrlWord[23] == $past(regWrData[23]))
      else $error("Filter fourteen enable not written");

   a_other_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      regWrite && regAddr != CAF_CTRL3_ADDR |=> $stable(ctrlWord))
      else $error("Control word moved on another address");

   // Read port stands one cycle and is zero otherwise
   a_idle_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      !regRead |=> regRdData == CAF_ZERO_WORD)
      else $error("Read data not zero when idle");

   a_refused_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      regRead && regAddr == CAF_WRITE_REFUSED_ADDR |=> regRdData[CAF_NUM_FILT-1:0] == $past(refused_reg))
      else $error("Refused flags read wrong");

   a_refused_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      regRead && regAddr == CAF_WRITE_REFUSED_ADDR |=> regRdData[CAF_DATA_W-1:CAF_NUM_FILT] == '0)
      else $error("Refused flags upper bits not zero");

   // A refused setting write raises its sticky flag two edges later
   a_refused_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      ctrlHit && ctrlWord[31] && (regWrData[30:24] != ctrlWord[30:24]) |=> ##1 refused_reg[3])
      else $error("Refused write to filter fifteen not flagged");
endmodule : caf_acceptance_filter_control

// [logic/caf_pkg.sv]
// Package with register map, field layout and reset values of the filter control block
package caf_pkg;
   localparam int CAF_ADDR_W = 4;
   localparam int CAF_DATA_W = 32;
   localparam int CAF_NUM_FILT = 4;
   localparam int CAF_SLOT_W = 8;
   localparam int CAF_MASK_W = 2;
   localparam int CAF_BUF_W = 5;
   localparam logic [CAF_ADDR_W-1:0] CAF_CTRL3_ADDR = 4'h0;
   localparam logic [CAF_ADDR_W-1:0] CAF_WRITE_REFUSED_ADDR = 4'h4;
   localparam logic [CAF_DATA_W-1:0] CAF_CTRL3_RESET = 32'h0000_0000;
   localparam logic [CAF_DATA_W-1:0] CAF_ZERO_WORD = 32'h0000_0000;
   localparam int CAF_ON_POS = 7;
   localparam int CAF_MASK_HI = 6;
   localparam int CAF_MASK_LO = 5;
   localparam int CAF_BUF_HI = 4;
   localparam int CAF_BUF_LO = 0;
   localparam int CAF_SLOT_SETTINGS_HI = 6;
   typedef logic [CAF_SLOT_W-1:0] caf_slot_t;
endpackage : caf_pkg

// [logic/caf_slot_if.sv]
// Interface carrying one filter slot's write request and stored value
`timescale 1ns/1ps
interface caf_slot_if;
   import caf_pkg::*;
   logic wrEn;
   caf_pkg::caf_slot_t wrData;
   caf_pkg::caf_slot_t slotVal;
   logic refused;
   modport ctrl (output wrEn, output wrData, input slotVal, input refused);
   modport slot (input wrEn, input wrData, output slotVal, output refused);
endinterface : caf_slot_if

// [logic/caf_filter_slot.sv]
// One filter slot: enable, mask pick and buffer pick with locked settings
`timescale 1ns/1ps
module caf_filter_slot
   import caf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   caf_slot_if.slot bus
);
   caf_slot_t slot_reg;
   caf_slot_t slot_next;
   logic refused_next;
   logic refused_reg;

   always_comb begin
      slot_next = slot_reg;
      refused_next = 1'b0;
      if (bus.wrEn) begin
         slot_next[CAF_ON_POS] = bus.wrData[CAF_ON_POS]; // R1
         if (!slot_reg[CAF_ON_POS]) begin
            slot_next[CAF_SLOT_SETTINGS_HI:0] = bus.wrData[CAF_SLOT_SETTINGS_HI:0]; // R7
         end else begin
            refused_next = (bus.wrData[CAF_SLOT_SETTINGS_HI:0] != slot_reg[CAF_SLOT_SETTINGS_HI:0]);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         slot_reg <= CAF_CTRL3_RESET[CAF_SLOT_W-1:0]; // R8
         refused_reg <= 1'b0;
      end else begin
         slot_reg <= slot_next;
         refused_reg <= refused_next;
      end
   end

   assign bus.slotVal = slot_reg;
   assign bus.refused = refused_reg;

   a_locked_settings_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      $past(slot_reg[CAF_ON_POS]) && $past(rst_n) |-> $stable(slot_reg[CAF_SLOT_SETTINGS_HI:0]))
      else $error("Settings changed while filter enabled");
   a_enable_follows_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
      bus.wrEn |=> slot_reg[CAF_ON_POS] == $past(bus.wrData[CAF_ON_POS]))
      else $error("Enable bit did not take written value");
   a_open_write_stores: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
      bus.wrEn && !slot_reg[CAF_ON_POS] |=> slot_reg == $past(bus.wrData))
      else $error("Write to disabled filter not stored");
endmodule : caf_filter_slot

// [dv/caf_testbench.sv]
// Self-checking bench for the acceptance filter control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin errCount++; \
   $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
   import caf_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [CAF_ADDR_W-1:0] regAddr = '0;
   logic [CAF_DATA_W-1:0] regWrData = '0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [CAF_DATA_W-1:0] regRdData;
   logic [CAF_NUM_FILT-1:0] filterOn;
   logic [CAF_NUM_FILT*CAF_MASK_W-1:0] filterMaskPick;
   logic [CAF_NUM_FILT*CAF_BUF_W-1:0] filterBufferPick;
   logic [CAF_DATA_W-1:0] rdVal;
   int errCount = 0;
   int nTests = 0;
   always #5 ref_clk = ~ref_clk;
   caf_acceptance_filter_control DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .filterOn(filterOn), .filterMaskPick(filterMaskPick), .filterBufferPick(filterBufferPick));
   task automatic wr(input logic [CAF_ADDR_W-1:0] a, input logic [CAF_DATA_W-1:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [CAF_ADDR_W-1:0] a);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1;
      rdVal = regRdData;
   endtask : rd
   task automatic reset_values();
      rd(CAF_CTRL3_ADDR);
      `CHK("control word", CAF_CTRL3_RESET, rdVal)
      `CHK("outputs", 32'h0000_0000, {filterOn, filterMaskPick, filterBufferPick})
   endtask : reset_values
   task automatic program_all();
      wr(CAF_CTRL3_ADDR, 32'hff80_cab5);
      rd(CAF_CTRL3_ADDR);
      `CHK("control word", 32'hff80_cab5, rdVal)
      `CHK("filter15 on", 1'b1, filterOn[3])
      `CHK("filter15 mask", 2'b11, filterMaskPick[7:6])
      `CHK("filter15 buffer", 5'h1f, filterBufferPick[19:15])
      `CHK("filter14 on", 1'b1, filterOn[2])
      `CHK("filter14 mask", 2'b00, filterMaskPick[5:4])
      `CHK("filter14 buffer", 5'h00, filterBufferPick[14:10])
      `CHK("filter13 12", {2'b11, 4'h9, 10'h155}, {filterOn[1:0], filterMaskPick[3:0], filterBufferPick[9:0]})
      @(posedge ref_clk);
      #1;
      `CHK("read data idle", CAF_ZERO_WORD, regRdData)
   endtask : program_all
   task automatic locked_write();
      wr(CAF_CTRL3_ADDR, CAF_ZERO_WORD);
      rd(CAF_CTRL3_ADDR);
      `CHK("locked settings", 32'h7f00_4a35, rdVal)
      `CHK("enables cleared", 4'h0, filterOn)
      `CHK("mask kept", 8'hc9, filterMaskPick)
      rd(CAF_WRITE_REFUSED_ADDR);
      `CHK("refused flags", 32'h0000_000b, rdVal)
      wr(CAF_WRITE_REFUSED_ADDR, 32'h0000_000f);
      rd(CAF_WRITE_REFUSED_ADDR);
      `CHK("flags cleared", CAF_ZERO_WORD, rdVal)
      wr(CAF_CTRL3_ADDR, 32'h5f2a_3f01);
      rd(CAF_CTRL3_ADDR);
      `CHK("unlocked settings", 32'h5f2a_3f01, rdVal)
      `CHK("new buffers", 20'hfabe1, filterBufferPick)
      `CHK("new masks", 8'h94, filterMaskPick)
   endtask : locked_write
   task automatic unmapped();
      wr(4'h8, 32'hffff_ffff);
      rd(4'h8);
      `CHK("unmapped read", CAF_ZERO_WORD, rdVal)
      rd(CAF_CTRL3_ADDR);
      `CHK("control untouched", 32'h5f2a_3f01, rdVal)
   endtask : unmapped
   task automatic endOfTest();
      $display("Comparisons %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : endOfTest
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      reset_values();
      program_all();
      locked_write();
      unmapped();
      endOfTest();
   end
endmodule : testbench
